// [src/sdram_bank_state_cke_control.sv]
// Command decode, per-bank state and CKE power control of a four-bank SDRAM.
// Assumes async command pins and an array side on ref_clk.
//
// Behaviour
// RULE1: Write burst mode bit forces single-beat writes
// RULE2: Reads always use programmed length and sequence
// RULE3: Access to other bank during auto-precharge accepted
// RULE4: Read interrupts AP read; precharge starts immediately
// RULE5: Write interrupts AP read; read output killed
// RULE6: Controller masks DQM two clocks before write
// RULE7: Read interrupts AP write; precharge after tWR
// RULE8: Write interrupts AP write; precharge after tWR
// RULE9: CKE with NOP enters/exits power-down when idle
// RULE10: Power-down exit: commands taken next edge
// RULE11: Self refresh exit waits tXSR before commands
// RULE12: Controller sends only NOPs during tXSR
// RULE13: Clock suspend exit: decode next edge
// RULE14: Burst terminate code enters deep power-down
// RULE15: CS high inhibit, all-high NOP continue
// RULE16: RAS/CAS/WE decoded into seven commands
// RULE17: Idle after tRP; accepts activate, refresh
// RULE18: Precharge truncates non-AP burst on bank
// RULE19: Non-AP burst takes new access or terminate
// RULE20: Activating for tRCD, then row active
// RULE21: Controller leaves busy banks alone
// RULE22: AP access busy until tRP after precharge
// RULE23: CKE low with refresh or burst: self/suspend
// RULE24: A10 picks one bank or all banks
`include "sdram_ctl_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module sdram_bank_state_cke_control #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 13,
  parameter int COL_W = 9,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic dqm,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  output logic array_rd_req,
  output logic [1:0] array_rd_bank,
  output logic [COL_W-1:0] array_rd_col,
  input wire logic [DATA_W-1:0] array_rd_data,
  output logic array_wr_valid,
  input wire logic array_wr_ready,
  output logic [2+COL_W+DATA_W-1:0] array_wr_data,
  output logic wr_fifo_ready,
  output sdram_pkg::bank_state_t bank_state [4],
  output sdram_pkg::pwr_state_t power_state,
  output logic all_banks_idle,
  output logic write_burst_mode_bit,
  output logic [2:0] burst_len_code,
  output logic [2:0] cas_latency
);
  import sdram_pkg::*;

  localparam int PIN_W = 5 + 2 + ADDR_W + 1 + DATA_W;
  localparam logic [`TMR_W-1:0] RCD_C = `TMR_W'(`T_RCD_CYC);
  localparam logic [`TMR_W-1:0] RP_C = `TMR_W'(`T_RP_CYC);
  localparam logic [`TMR_W-1:0] WR_C = `TMR_W'(`T_WR_CYC);
  localparam logic [`TMR_W-1:0] RFC_C = `TMR_W'(`T_RFC_CYC);
  localparam logic [`TMR_W-1:0] XSR_C = `TMR_W'(`T_XSR_CYC);
  localparam logic [`TMR_W-1:0] MRD_C = `TMR_W'(`T_MRD_CYC);
  localparam logic [`TMR_W-1:0] TMR_ONE = `TMR_W'(1);

  // Command decode from the sampled pins
  function automatic cmd_t decode_cmd(input logic csn, input logic [2:0] rcw);
    cmd_t c;
    c = cmd_nop;
    if (csn) c = cmd_inhibit;
    else
    begin
      unique case (rcw)
        3'h7: c = cmd_nop;
        3'h3: c = cmd_active;
        3'h5: c = cmd_read;
        3'h4: c = cmd_write;
        3'h2: c = cmd_precharge;
        3'h1: c = cmd_refresh;
        3'h0: c = cmd_mode_load;
        3'h6: c = cmd_burst_term;
      endcase
    end
    return c;
  endfunction : decode_cmd

  // Burst length in beats from the mode code
  function automatic logic [COL_W:0] bl_beats(input logic [2:0] code);
    logic [COL_W:0] n;
    n = (COL_W+1)'(1) << code[1:0];
    return n;
  endfunction : bl_beats

  // Column of beat idx, wrapping inside the burst window
  function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0] start, input logic [COL_W-1:0] idx,
    input logic [2:0] code, input logic ilv);
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] off;
    mask = (code == `BL_CODE_PAGE) ? '1 : COL_W'(bl_beats(code) - 1'b1);
    off = ilv ? (start ^ idx) : (start + idx);
    return (start & ~mask) | (off & mask);
  endfunction : beat_col

  // Two-flop synchroniser on every pin
  logic [PIN_W-1:0] pin_meta_ff;
  logic [PIN_W-1:0] pin_sync_ff;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end
    else
    begin
      pin_meta_ff <= {cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_in};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  wire s_cke = pin_sync_ff[PIN_W-1];
  wire s_cs_n = pin_sync_ff[PIN_W-2];
  wire [2:0] s_rcw = pin_sync_ff[PIN_W-3 -: 3];
  wire [1:0] s_ba = pin_sync_ff[PIN_W-6 -: 2];
  wire [ADDR_W-1:0] s_addr = pin_sync_ff[DATA_W+ADDR_W : DATA_W+1];
  wire s_dqm = pin_sync_ff[DATA_W];
  wire [DATA_W-1:0] s_dq = pin_sync_ff[DATA_W-1:0];

  // State registers
  logic cke_prev_ff;
  pwr_state_t pwr_ff;
  pwr_state_t nxt_pwr;
  logic [`TMR_W-1:0] pwr_tmr_ff;
  logic [`TMR_W-1:0] nxt_pwr_tmr;
  logic [`TMR_W-1:0] gbusy_ff;
  logic [2:0] mr_bl_ff;
  logic mr_bt_ff;
  logic [2:0] mr_cl_ff;
  logic mr_wbm_ff;
  logic bst_on_ff;
  logic bst_rd_ff;
  logic bst_page_ff;
  logic [1:0] bst_bank_ff;
  logic [COL_W-1:0] bst_start_ff;
  logic [COL_W-1:0] bst_idx_ff;
  logic [COL_W:0] bst_left_ff;
  logic [1:0] rp_v_ff;
  logic [DATA_W-1:0] rp_d_ff [2];
  logic [1:0] dqm_p_ff;
  bank_state_t state_ff [4];
  logic [3:0] bank_idle;

  // Commands run only with CKE high now and before
  cmd_t cmd;
  assign cmd = decode_cmd(s_cs_n, s_rcw); // RULE15 RULE16
  wire live = cke_prev_ff; // RULE13
  wire run_edge = (pwr_ff == pwr_run) && cke_prev_ff && s_cke; // RULE10 RULE11
  wire is_nop = (cmd == cmd_inhibit) || (cmd == cmd_nop); // RULE15
  wire do_act = run_edge && (cmd == cmd_active);
  wire do_rd = run_edge && (cmd == cmd_read);
  wire do_wr = run_edge && (cmd == cmd_write);
  wire do_pre = run_edge && (cmd == cmd_precharge);
  wire do_ref = run_edge && (cmd == cmd_refresh);
  wire do_mrl = run_edge && (cmd == cmd_mode_load);
  wire do_bt = run_edge && (cmd == cmd_burst_term); // RULE14
  wire do_rdwr = do_rd || do_wr;
  wire pre_all = s_addr[`AP_BIT]; // RULE24
  wire ap_req = s_addr[`AP_BIT];
  wire all_idle = (&bank_idle) && (gbusy_ff == '0);

  // Burst stepping and its ending conditions
  wire pre_stop = do_pre && (pre_all || (s_ba == bst_bank_ff)); // RULE18 RULE24
  wire intr = do_rdwr || do_bt || pre_stop; // RULE19
  wire step = live && bst_on_ff && !intr;
  wire nat_end = step && (bst_left_ff == (COL_W+1)'(1)) && !bst_page_ff;
  wire [COL_W:0] rd_len = bl_beats(mr_bl_ff); // RULE2
  wire [COL_W:0] wr_len = mr_wbm_ff ? (COL_W+1)'(1) : bl_beats(mr_bl_ff); // RULE1
  wire new_page = (mr_bl_ff == `BL_CODE_PAGE) && !(do_wr && mr_wbm_ff);
  wire [COL_W:0] wr_left = wr_len - 1'b1;

  // Array read request for each read beat
  wire rd_beat = step && bst_rd_ff;
  assign array_rd_req = rd_beat;
  assign array_rd_bank = bst_bank_ff;
  assign array_rd_col = beat_col(bst_start_ff, bst_idx_ff, mr_bl_ff, mr_bt_ff); // RULE2

  // Write beats: the command's own beat, then one per live edge
  wire wr_cmd_beat = do_wr && !s_dqm;
  wire wr_step_beat = step && !bst_rd_ff && !s_dqm; // RULE7 RULE8
  wire [COL_W-1:0] wr_col = wr_cmd_beat ? s_addr[COL_W-1:0]
    : beat_col(bst_start_ff, bst_idx_ff, mr_bl_ff, mr_bt_ff);
  wire [1:0] wr_bank = wr_cmd_beat ? s_ba : bst_bank_ff;

  sync_fifo #(
    .WIDTH(2+COL_W+DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(wr_cmd_beat || wr_step_beat),
    .in_ready(wr_fifo_ready),
    .in_data({wr_bank, wr_col, s_dq}),
    .out_valid(array_wr_valid),
    .out_ready(array_wr_ready),
    .out_data(array_wr_data)
  );

  // Burst engine; holds while the internal clock is suspended
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      bst_on_ff <= 1'b0;
      bst_rd_ff <= 1'b0;
      bst_page_ff <= 1'b0;
      bst_bank_ff <= '0;
      bst_start_ff <= '0;
      bst_idx_ff <= '0;
      bst_left_ff <= '0;
    end
    else if (do_rdwr)
    begin
      bst_on_ff <= do_rd || new_page || (wr_left != '0); // RULE1 RULE19
      bst_rd_ff <= do_rd;
      bst_page_ff <= new_page;
      bst_bank_ff <= s_ba;
      bst_start_ff <= s_addr[COL_W-1:0];
      bst_idx_ff <= do_rd ? '0 : COL_W'(1);
      bst_left_ff <= do_rd ? rd_len : wr_left;
    end
    else if (do_bt || pre_stop || nat_end)
      bst_on_ff <= 1'b0; // RULE18 RULE19
    else if (step)
    begin
      bst_idx_ff <= bst_idx_ff + 1'b1;
      bst_left_ff <= bst_left_ff - 1'b1;
    end
  end

  // Read data pipeline; a write kills queued read data
  always_ff @(posedge ref_clk)
  begin
    if (reset || do_wr)
      rp_v_ff <= '0; // RULE5
    else if (live)
      rp_v_ff <= {rp_v_ff[0], rd_beat}; // RULE4
  end

  always_ff @(posedge ref_clk)
  begin
    if (live)
    begin
      rp_d_ff[0] <= array_rd_data;
      rp_d_ff[1] <= rp_d_ff[0];
    end
    dqm_p_ff <= reset ? 2'h3 : {dqm_p_ff[0], s_dqm};
  end

  // CL tap two or three; DQM masks two edges later
  wire cl3 = (mr_cl_ff == `CL_THREE);
  assign dq_out = cl3 ? rp_d_ff[1] : rp_d_ff[0];
  assign dq_oe_n = !((cl3 ? rp_v_ff[1] : rp_v_ff[0]) && !dqm_p_ff[1]); // RULE6

  // Mode register and the global refresh / mode-load busy time
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      mr_bl_ff <= `MR_BL_RST;
      mr_bt_ff <= 1'b0;
      mr_cl_ff <= `MR_CL_RST;
      mr_wbm_ff <= 1'b0;
      gbusy_ff <= '0;
    end
    else
    begin
      if (do_mrl && all_idle)
      begin
        mr_bl_ff <= s_addr[`MR_BL_MSB:`MR_BL_LSB];
        mr_bt_ff <= s_addr[`MR_BT_BIT];
        mr_cl_ff <= s_addr[`MR_CL_MSB:`MR_CL_LSB];
        mr_wbm_ff <= s_addr[`MR_WBM_BIT]; // RULE1
      end
      if (do_ref && all_idle) gbusy_ff <= RFC_C; // RULE17
      else if (do_mrl && all_idle) gbusy_ff <= MRD_C;
      else if (gbusy_ff != '0) gbusy_ff <= gbusy_ff - 1'b1;
    end
  end

  // Per-bank state machines
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++)
    begin : g_bank
      logic [`TMR_W-1:0] tmr_ff;
      logic [`TMR_W-1:0] nxt_tmr;
      bank_state_t nxt_state;
      wire hit = (s_ba == 2'(gb));
      wire pre_hit = do_pre && (pre_all || hit); // RULE24
      wire own = bst_on_ff && (bst_bank_ff == 2'(gb));
      wire ends = own && (nat_end || do_bt || (do_rdwr && !hit)); // RULE3
      wire tdone = (tmr_ff == TMR_ONE);
      wire [3:0] rdwr_state = do_rd ? (ap_req ? bs_read_ap : bs_reading) : (ap_req ? bs_write_ap : bs_writing);

      always_comb
      begin
        nxt_state = state_ff[gb];
        nxt_tmr = (tmr_ff != '0) ? tmr_ff - 1'b1 : tmr_ff;
        unique case (state_ff[gb])
          bs_idle:
            if (do_act && hit)
            begin
              nxt_state = bs_activating; // RULE17 RULE20
              nxt_tmr = RCD_C;
            end
          bs_activating:
            if (tdone) nxt_state = bs_active; // RULE20
          bs_active, bs_reading, bs_writing:
            if (pre_hit)
            begin
              nxt_state = bs_precharging; // RULE18 RULE22
              nxt_tmr = RP_C;
            end
            else if (do_rdwr && hit) nxt_state = bank_state_t'(rdwr_state); // RULE19 RULE20
            else if (ends) nxt_state = bs_active; // RULE19
          bs_read_ap:
            if (ends)
            begin
              nxt_state = bs_precharging; // RULE4 RULE5 RULE22
              nxt_tmr = RP_C;
            end
          bs_write_ap:
            if (ends)
            begin
              nxt_state = bs_recovering; // RULE7 RULE8
              nxt_tmr = WR_C;
            end
          bs_recovering:
            if (tdone)
            begin
              nxt_state = bs_precharging; // RULE7 RULE8 RULE22
              nxt_tmr = RP_C;
            end
          bs_precharging:
            if (tdone) nxt_state = bs_idle; // RULE17 RULE22
          default:
            nxt_state = bs_idle;
        endcase
      end

      always_ff @(posedge ref_clk)
      begin
        if (reset)
        begin
          state_ff[gb] <= bs_idle;
          tmr_ff <= '0;
        end
        else
        begin
          state_ff[gb] <= nxt_state;
          tmr_ff <= nxt_tmr;
        end
      end

      assign bank_idle[gb] = (state_ff[gb] == bs_idle);
      assign bank_state[gb] = state_ff[gb];
    end
  endgenerate

  // Power state machine on CKE now and before
  wire cke_fall = (pwr_ff == pwr_run) && cke_prev_ff && !s_cke;
  always_comb
  begin
    nxt_pwr = pwr_ff;
    nxt_pwr_tmr = (pwr_tmr_ff != '0) ? pwr_tmr_ff - 1'b1 : pwr_tmr_ff;
    unique case (pwr_ff)
      pwr_run:
        if (cke_fall)
        begin
          if (all_idle && is_nop) nxt_pwr = pwr_down; // RULE9
          else if (all_idle && (cmd == cmd_burst_term)) nxt_pwr = pwr_deep; // RULE14
          else if (all_idle && (cmd == cmd_refresh)) nxt_pwr = pwr_self; // RULE23
          else if (bst_on_ff) nxt_pwr = pwr_suspend; // RULE23
        end
      pwr_down:
        if (s_cke && is_nop) nxt_pwr = pwr_run; // RULE9 RULE10
      pwr_self:
        if (s_cke && is_nop)
        begin
          nxt_pwr = pwr_xsr; // RULE11
          nxt_pwr_tmr = XSR_C;
        end
      pwr_xsr:
        if (pwr_tmr_ff == TMR_ONE) nxt_pwr = pwr_run; // RULE11 RULE12
      pwr_suspend:
        if (s_cke) nxt_pwr = pwr_run; // RULE13
      pwr_deep:
        if (s_cke) nxt_pwr = pwr_run; // RULE14
      default:
        nxt_pwr = pwr_run;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pwr_ff <= pwr_run;
      pwr_tmr_ff <= '0;
      cke_prev_ff <= 1'b0;
    end
    else
    begin
      pwr_ff <= nxt_pwr;
      pwr_tmr_ff <= nxt_pwr_tmr;
      cke_prev_ff <= s_cke;
    end
  end

  // Status outputs
  assign power_state = pwr_ff;
  assign all_banks_idle = all_idle && (pwr_ff == pwr_run);
  assign write_burst_mode_bit = mr_wbm_ff;
  assign burst_len_code = mr_bl_ff;
  assign cas_latency = mr_cl_ff;

endmodule : sdram_bank_state_cke_control
`default_nettype wire

// [src/sdram_ctl_consts.svh]
// Constants for the SDRAM bank state and CKE control block.
// Assumes a 250 MHz ref_clk; ns times become cycles here.
`ifndef SDRAM_CTL_CONSTS_SVH
`define SDRAM_CTL_CONSTS_SVH

// Clock period
`define CLK_PERIOD_NS 4

// Least times in ns, tMRD in cycles (plain defaults, tune per part)
`define T_RCD_NS 20
`define T_RP_NS 20
`define T_WR_NS 15
`define T_RFC_NS 80
`define T_XSR_NS 120
`define T_MRD_CYC 2

// Least times round up to whole cycles
`define NS_TO_CYC(t) ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define T_RCD_CYC `NS_TO_CYC(`T_RCD_NS)
`define T_RP_CYC `NS_TO_CYC(`T_RP_NS)
`define T_WR_CYC `NS_TO_CYC(`T_WR_NS)
`define T_RFC_CYC `NS_TO_CYC(`T_RFC_NS)
`define T_XSR_CYC `NS_TO_CYC(`T_XSR_NS)

// Timer width
`define TMR_W 8

// Mode register fields on the address pins
`define MR_BL_LSB 0
`define MR_BL_MSB 2
`define MR_BT_BIT 3
`define MR_CL_LSB 4
`define MR_CL_MSB 6
`define MR_WBM_BIT 9

// Auto precharge / precharge-all select
`define AP_BIT 10

// Mode reset values and codes
`define MR_BL_RST 3'h0
`define MR_CL_RST 3'h3
`define CL_THREE 3'h3
`define BL_CODE_PAGE 3'h7

`endif

// [src/sdram_pkg.sv]
// Types shared by the SDRAM bank state and CKE control block.
// Assumes the constants header is compiled alongside.
package sdram_pkg;

  typedef enum logic [3:0] {
    cmd_inhibit = 4'h0,
    cmd_nop = 4'h1,
    cmd_active = 4'h2,
    cmd_read = 4'h3,
    cmd_write = 4'h4,
    cmd_precharge = 4'h5,
    cmd_refresh = 4'h6,
    cmd_mode_load = 4'h7,
    cmd_burst_term = 4'h8
  } cmd_t;

  typedef enum logic [3:0] {
    bs_idle = 4'h0,
    bs_activating = 4'h1,
    bs_active = 4'h2,
    bs_reading = 4'h3,
    bs_writing = 4'h4,
    bs_read_ap = 4'h5,
    bs_write_ap = 4'h6,
    bs_recovering = 4'h7,
    bs_precharging = 4'h8
  } bank_state_t;

  typedef enum logic [2:0] {
    pwr_run = 3'h0,
    pwr_down = 3'h1,
    pwr_self = 3'h2,
    pwr_xsr = 3'h3,
    pwr_suspend = 3'h4,
    pwr_deep = 3'h5
  } pwr_state_t;

endpackage : sdram_pkg

// [src/sync_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] count_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Full and empty from the fill count
  assign in_ready = (count_ff != (PW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];

  // Pointers and fill level
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push) wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Storage
  always_ff @(posedge ref_clk)
  begin
    if (push) mem_ff[wr_ptr_ff] <= in_data;
  end

endmodule : sync_fifo
`default_nettype wire

// [verification/ctl_model.sv]
// Controller model driving command, address, mask and data pins.
// Assumes the bench calls op() and nop(); pins move on falling edges.
`timescale 1ns/1ns
`default_nettype none
module ctl_model (
  input wire logic ref_clk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic [12:0] addr,
  output logic dqm,
  output logic [15:0] dq_in
);
  import sdram_pkg::*;
  // Quiet bus at time zero: clock enabled, NOP
  initial
  begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    {ba, addr, dqm, dq_in} = '0;
  end
  // Pins {cs_n, ras_n, cas_n, we_n} per command
  function automatic logic [3:0] enc(input cmd_t c);
    case (c)
      cmd_inhibit: enc = 4'h8;
      cmd_active: enc = 4'h3;
      cmd_read: enc = 4'h5;
      cmd_write: enc = 4'h4;
      cmd_precharge: enc = 4'h2;
      cmd_refresh: enc = 4'h1;
      cmd_mode_load: enc = 4'h0;
      cmd_burst_term: enc = 4'h6;
      default: enc = 4'h7;
    endcase
  endfunction : enc
  // One command cycle; data flips unless writing
  task automatic op(input cmd_t c, input logic [1:0] b = 2'h0, input logic [12:0] a = 13'h0000,
                    input logic [15:0] d = 16'h0000, input logic k = 1'b1, input logic m = 1'b0);
    @(negedge ref_clk);
    cke = k;
    {cs_n, ras_n, cas_n, we_n} = enc(c);
    ba = b;
    addr = a;
    dqm = m;
    dq_in = (c == cmd_write) ? d : ~dq_in;
  endtask : op
  // NOP only, so busy banks stay untouched
  task automatic nop(input int n);
    repeat (n) op(cmd_nop);
  endtask : nop
endmodule : ctl_model
`default_nettype wire

// [verification/sdram_bank_state_cke_control_assertions.sv]
// Concurrent checks on bank and power state.
// Assumes ref_clk and synchronous high reset; bound into the top.
`timescale 1ns/1ns
`default_nettype none
module bank_state_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire sdram_pkg::bank_state_t bank_state [4],
  input wire sdram_pkg::pwr_state_t power_state,
  input wire logic all_banks_idle
);
  import sdram_pkg::*;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // Timers expire into the next state; idle flag needs idle banks
  chk_rcd_to_active: assert property (
    $rose(bank_state[0] == bs_activating) |-> ##[4:6] bank_state[0] == bs_active)
    else $error("row activation overran");
  chk_rp_to_idle: assert property (
    $rose(bank_state[1] == bs_precharging) |-> ##[4:6] bank_state[1] == bs_idle)
    else $error("precharge overran");
  chk_idle_flag: assert property (
    all_banks_idle |-> bank_state[0] == bs_idle && bank_state[1] == bs_idle && power_state == pwr_run)
    else $error("idle flag with a busy bank");
  // Power state moves
  chk_pd_entry: assert property (
    $rose(power_state == pwr_down) |-> $past(all_banks_idle))
    else $error("power-down entered while busy");
  chk_pd_exit: assert property (
    power_state == pwr_run && $past(power_state) == pwr_down |-> all_banks_idle)
    else $error("power-down exit not idle");
  chk_xsr_wait: assert property (
    $rose(power_state == pwr_xsr) |-> (!all_banks_idle) [*8] ##[20:24] power_state == pwr_run)
    else $error("self refresh exit wait wrong");
  chk_deep_exit: assert property (
    power_state == pwr_deep |=> power_state inside {pwr_deep, pwr_run})
    else $error("deep power-down left wrongly");
  // Bank 1 access cuts bank 0 auto precharge
  chk_ap_read_cut: assert property (
    $past(bank_state[0]) == bs_read_ap && $past(bank_state[1]) == bs_active
    && bank_state[1] inside {bs_reading, bs_read_ap, bs_writing, bs_write_ap} |-> bank_state[0] == bs_precharging)
    else $error("read auto precharge not cut");
  chk_ap_write_cut: assert property (
    $past(bank_state[0]) == bs_write_ap && $past(bank_state[1]) == bs_active && bank_state[1] == bs_writing
    |-> bank_state[0] == bs_recovering ##[3:5] bank_state[0] == bs_precharging)
    else $error("write auto precharge not cut");
  cover property (power_state == pwr_deep);
  cover property ($rose(power_state == pwr_xsr));
  cover property (bank_state[0] == bs_recovering);
endmodule : bank_state_checker
bind sdram_bank_state_cke_control bank_state_checker chk_i (.ref_clk, .reset, .bank_state, .power_state,
  .all_banks_idle);
`default_nettype wire

// [verification/sdram_bank_state_cke_control_bench.sv]
// Self-checking bench for the SDRAM bank control block.
// Assumes ctl_model drives pins; the bench plays array and drain.
`timescale 1ns/1ns
`default_nettype none
module sdram_bank_state_cke_control_bench;
  import sdram_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic array_wr_ready = 1'b0;
  logic stall = 1'b0;
  wire logic cke, cs_n, ras_n, cas_n, we_n, dqm, dq_oe_n, array_rd_req, array_wr_valid;
  wire logic wr_fifo_ready, all_banks_idle, write_burst_mode_bit;
  wire logic [1:0] ba, array_rd_bank;
  wire logic [12:0] addr;
  wire logic [15:0] dq_in, dq_out;
  wire logic [8:0] array_rd_col;
  wire logic [26:0] array_wr_data;
  wire logic [2:0] burst_len_code, cas_latency;
  bank_state_t bank_state [4];
  pwr_state_t power_state;
  int fails = 0, samples_checked = 0, n_rd = 0, n_dq = 0, n_wr = 0;
  logic [26:0] first_wr;
  logic [15:0] first_dq;
  // Array returns a pattern built only from the beat address
  wire logic [15:0] array_rd_data = {array_rd_bank, ~array_rd_col[4:0], array_rd_col};

  ctl_model ctl (.ref_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dqm, .dq_in);
  sdram_bank_state_cke_control dut (.ref_clk, .reset, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dqm,
    .dq_in, .dq_out, .dq_oe_n, .array_rd_req, .array_rd_bank, .array_rd_col, .array_rd_data, .array_wr_valid,
    .array_wr_ready, .array_wr_data, .wr_fifo_ready, .bank_state, .power_state, .all_banks_idle,
    .write_burst_mode_bit, .burst_len_code, .cas_latency);

  always #2 ref_clk = ~ref_clk;
  // Drain every other cycle unless stalled
  always @(negedge ref_clk) array_wr_ready <= stall ? 1'b0 : ~array_wr_ready;
  // Count read beats, driven and drained words
  always @(posedge ref_clk)
  begin
    if (array_rd_req) n_rd++;
    if (!dq_oe_n)
    begin
      if (n_dq == 0) first_dq = dq_out;
      n_dq++;
    end
    if (array_wr_valid && array_wr_ready)
    begin
      if (n_wr == 0) first_wr = array_wr_data;
      n_wr++;
    end
  end

  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : cmp
  task automatic clr();
    n_rd = 0;
    n_dq = 0;
    n_wr = 0;
  endtask : clr
  // Bounded state waits
  task automatic wait_bank(input int b, input bank_state_t s);
    for (int i = 0; i < 60 && bank_state[b] !== s; i++) @(negedge ref_clk);
  endtask : wait_bank
  task automatic wait_pwr(input pwr_state_t s);
    for (int i = 0; i < 60 && power_state !== s; i++) @(negedge ref_clk);
  endtask : wait_pwr

  // Reset values, then single-beat writes
  task automatic t_mode_write();
    cmp(cas_latency, 3'h3);
    cmp(all_banks_idle, 1'b1);
    ctl.op(cmd_mode_load, 2'h0, 13'h0221);
    ctl.nop(4);
    cmp(write_burst_mode_bit, 1'b1);
    cmp({burst_len_code, cas_latency}, 6'h0a);
    ctl.op(cmd_active);
    ctl.nop(3);
    cmp(bank_state[0], bs_activating);
    wait_bank(0, bs_active);
    clr();
    ctl.op(cmd_write, 2'h0, 13'h0008, 16'ha5c3);
    ctl.nop(12);
    cmp(n_wr, 1);
    cmp(first_wr, {2'h0, 9'h008, 16'ha5c3});
    ctl.op(cmd_precharge);
    wait_bank(0, bs_idle);
    cmp(bank_state[0], bs_idle);
  endtask : t_mode_write
  // Reads keep programmed length
  task automatic t_read();
    ctl.op(cmd_mode_load, 2'h0, 13'h0021);
    ctl.nop(4);
    cmp(write_burst_mode_bit, 1'b0);
    ctl.op(cmd_active);
    wait_bank(0, bs_active);
    clr();
    ctl.op(cmd_read, 2'h0, 13'h0004);
    ctl.nop(10);
    cmp(n_rd, 2);
    cmp(n_dq, 2);
    cmp(first_dq, {2'h0, 5'h1b, 9'h004});
    cmp(bank_state[0], bs_active);
  endtask : t_read
  // Bank 1 accesses cut auto-precharge accesses on bank 0
  task automatic t_auto_pre();
    ctl.op(cmd_active, 2'h1);
    wait_bank(1, bs_active);
    ctl.op(cmd_read, 2'h0, 13'h0404);
    ctl.op(cmd_read, 2'h1);
    ctl.nop(3);
    cmp(bank_state[1], bs_reading);
    cmp(bank_state[0], bs_precharging);
    wait_bank(0, bs_idle);
    cmp(bank_state[0], bs_idle);
    ctl.op(cmd_active);
    wait_bank(0, bs_active);
    clr();
    ctl.op(cmd_read, 2'h0, 13'h0404, '0, 1'b1, 1'b1);
    ctl.op(cmd_write, 2'h1, '0, 16'h5a5a);
    ctl.nop(3);
    cmp(bank_state[0], bs_precharging);
    ctl.nop(6);
    cmp(n_dq, 0);
    wait_bank(0, bs_idle);
    ctl.op(cmd_active);
    wait_bank(0, bs_active);
    ctl.op(cmd_write, 2'h0, 13'h0400);
    ctl.op(cmd_write, 2'h1);
    ctl.nop(3);
    cmp(bank_state[0], bs_recovering);
    wait_bank(0, bs_idle);
    cmp(bank_state[0], bs_idle);
  endtask : t_auto_pre
  // Precharge all; page write fills stalled buffer
  task automatic t_fifo();
    ctl.op(cmd_precharge, 2'h3, 13'h0400);
    ctl.nop(3);
    cmp(bank_state[1], bs_precharging);
    wait_bank(1, bs_idle);
    ctl.nop(1);
    cmp(all_banks_idle, 1'b1);
    ctl.op(cmd_mode_load, 2'h0, 13'h0027);
    ctl.op(cmd_active, 2'h2);
    wait_bank(2, bs_active);
    stall = 1'b1;
    clr();
    ctl.op(cmd_write, 2'h2, 13'h0000, 16'h0100);
    ctl.nop(20);
    cmp(wr_fifo_ready, 1'b0);
    ctl.op(cmd_burst_term, 2'h2);
    ctl.nop(3);
    cmp(bank_state[2], bs_active);
    stall = 1'b0;
    ctl.nop(45);
    cmp(n_wr, 16);
    cmp(first_wr, {2'h2, 9'h000, 16'h0100});
    ctl.op(cmd_precharge, 2'h0, 13'h0400);
    wait_bank(2, bs_idle);
    ctl.nop(1);
  endtask : t_fifo
  // Power-down, self refresh and deep power-down
  task automatic t_power();
    ctl.op(cmd_nop, '0, '0, '0, 1'b0);
    wait_pwr(pwr_down);
    cmp(power_state, pwr_down);
    ctl.op(cmd_nop);
    ctl.nop(3);
    cmp(all_banks_idle, 1'b1);
    ctl.op(cmd_refresh, '0, '0, '0, 1'b0);
    wait_pwr(pwr_self);
    cmp(power_state, pwr_self);
    ctl.op(cmd_nop);
    ctl.nop(4);
    cmp({power_state, all_banks_idle}, {pwr_xsr, 1'b0});
    ctl.nop(32);
    cmp(power_state, pwr_run);
    ctl.op(cmd_burst_term, '0, '0, '0, 1'b0);
    wait_pwr(pwr_deep);
    cmp(power_state, pwr_deep);
    ctl.op(cmd_nop);
    wait_pwr(pwr_run);
    cmp(power_state, pwr_run);
  endtask : t_power

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    ctl.nop(4);
    t_mode_write();
    t_read();
    t_auto_pre();
    t_fifo();
    t_power();
    stop_test();
  end
  // Watchdog; the run needs under 2000 cycles
  initial
  begin
    #(4 * 5000);
    fails++;
    stop_test();
  end
endmodule : sdram_bank_state_cke_control_bench
`default_nettype wire
